// >>> rtl/reset_sources_watchdog.sv
// Reset sources, reset pin driver and watchdog with an AHB-Lite register port.
// Assumes the reset pin is open drain with a pull-up and that a second party may
// pull it; the E clock is an enable derived from CLK_SYS.
// Notes on behaviour
// - Pin, power-on, clock loss, watchdog all reset
// - Pin low after power delay keeps reset
// - Watchdog expiry resets and drives pin low
// - Watchdog enabled out of reset; writing disables
// - Disable bit takes only first write; any write in special mode
// - Rate field divides base by 1,4,16,64
// - Arm with 55, then AA restarts count
// - Any accesses allowed between arm and clear
// - Clock loss resets and drives pin low
// - Clock monitor works only when enabled
// - Rate writable once in first 64 E; any time in special mode
// - Timebase is E divided by 2^15
//
// The address map and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module reset_sources_watchdog #(
	parameter int unsigned E_DIV = rsw_pkg::E_DIV,
	parameter int unsigned WD_BASE_LOG2 = rsw_pkg::WD_BASE_LOG2,
	parameter int unsigned POR_DELAY_E = rsw_pkg::POR_DELAY_E,
	parameter int unsigned CLKMON_FAIL_CYC = rsw_pkg::CLKMON_FAIL_CYC
)(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic HREADY,
	input wire logic [31:0] HWDATA,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Open-drain reset pin
	input wire logic RESET_N_I,
	output logic RESET_N_O,
	output logic RESET_N_OE,
	// Mode strap and monitored clock pin
	input wire logic SPECIAL_MODE,
	input wire logic ECLK_MON,
	// System side
	output logic SYS_RST,
	output logic E_TICK,
	output logic IRQ
);
	localparam int unsigned EW = $clog2(E_DIV + 1);
	localparam logic [EW-1:0] E_LAST = EW'(E_DIV - 1);
	localparam int unsigned WDW = WD_BASE_LOG2 + rsw_pkg::WD_PRESCALE_BITS;
	localparam logic [15:0] POR_LAST = 16'(POR_DELAY_E - 1);
	localparam logic [15:0] DRIVE_LAST = 16'(rsw_pkg::DRIVE_E - 1);
	localparam logic [6:0] WIN_END = 7'(rsw_pkg::OPT_WINDOW_E);

	// Expiry value of the watchdog count for a rate field
	function automatic logic [WDW-1:0] wd_limit(input logic [1:0] sel);
		logic [WDW:0] span;
		span = '0;
		span[WD_BASE_LOG2 + 2 * sel] = 1'b1;
		return WDW'(span - 1'b1);
	endfunction

	// Synchronisers
	logic pin_s1_r, pin_s2_r, spec_s1_r, spec_s2_r;
	// E divider
	logic [EW-1:0] e_cnt_r, e_cnt_nxt;
	logic e_tick_r, e_tick_nxt;
	// Bus
	logic wr_pend_r, wr_pend_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	// Control
	logic wd_dis_r, wd_dis_nxt, dis_lock_r, dis_lock_nxt;
	logic [1:0] rate_r, rate_nxt;
	logic rate_lock_r, rate_lock_nxt, clkchk_r, clkchk_nxt;
	logic [6:0] win_cnt_r, win_cnt_nxt;
	logic armed_r, armed_nxt;
	logic [WDW-1:0] wd_cnt_r, wd_cnt_nxt;
	// Reset sequencer and events
	rsw_pkg::rst_state_t state_r, state_nxt;
	logic [15:0] rcnt_r, rcnt_nxt;
	logic sys_rst_r, sys_rst_nxt, drive_r, drive_nxt;
	logic [3:0] status_r, status_nxt, mask_r, mask_nxt, ev;
	logic irq_r, irq_nxt;

	logic run, special, win_open, clk_fail, wd_fire, svc_clear;
	logic bus_take, wr_cfg, wr_opt, wr_svc, wr_stat, wr_mask;

	assign run = (state_r == rsw_pkg::RS_RUN);
	assign special = spec_s2_r;
	assign win_open = (win_cnt_r != WIN_END);
	assign bus_take = HSEL && HREADY && HTRANS[1];
	assign wr_cfg = wr_pend_r && (addr_r == rsw_pkg::OFF_CONFIG) && run;
	assign wr_opt = wr_pend_r && (addr_r == rsw_pkg::OFF_OPTION) && run;
	assign wr_svc = wr_pend_r && (addr_r == rsw_pkg::OFF_SERVICE) && run;
	assign wr_stat = wr_pend_r && (addr_r == rsw_pkg::OFF_STATUS);
	assign wr_mask = wr_pend_r && (addr_r == rsw_pkg::OFF_MASK);

	// Clock-loss detector, active only in run with its enable set
	clock_check #(
		.FAIL_CYC(CLKMON_FAIL_CYC)
	) u_clock_check (
		.clk(CLK_SYS),
		.rst(RST),
		.enable(clkchk_r && run),
		.mon_pin(ECLK_MON),
		.fail(clk_fail)
	);

	// E-clock enable divider
	always_comb
	begin
		e_cnt_nxt = (e_cnt_r == E_LAST) ? '0 : e_cnt_r + 1'b1;
		e_tick_nxt = (e_cnt_r == E_LAST);
	end

	// Bus address phase capture; reads answer with no wait state
	always_comb
	begin
		wr_pend_nxt = bus_take && HWRITE;
		addr_nxt = bus_take ? HADDR[7:0] : addr_r;
		rdata_nxt = rdata_r;
		if (bus_take && !HWRITE)
		begin
			case (HADDR[7:0])
				rsw_pkg::OFF_CONFIG: rdata_nxt = {31'h0, wd_dis_r};
				rsw_pkg::OFF_OPTION: rdata_nxt = {28'h0, clkchk_r, 1'b0, rate_r};
				rsw_pkg::OFF_STATUS: rdata_nxt = {28'h0, status_r};
				rsw_pkg::OFF_MASK: rdata_nxt = {28'h0, mask_r};
				rsw_pkg::OFF_STATE: rdata_nxt = {27'h0, !wd_dis_r, special, pin_s2_r,
					win_open, armed_r};
				rsw_pkg::OFF_WDCOUNT: rdata_nxt = 32'(wd_cnt_r);
				default: rdata_nxt = 32'h0;
			endcase
		end
	end

	// Control bits; all return to reset values while the system is in reset
	always_comb
	begin
		wd_dis_nxt = wd_dis_r;
		dis_lock_nxt = dis_lock_r;
		rate_nxt = rate_r;
		rate_lock_nxt = rate_lock_r;
		clkchk_nxt = clkchk_r;
		win_cnt_nxt = win_cnt_r;
		armed_nxt = armed_r;
		if (!run)
		begin
			wd_dis_nxt = rsw_pkg::WD_DIS_RST;
			dis_lock_nxt = 1'b0;
			rate_nxt = rsw_pkg::RATE_RST;
			rate_lock_nxt = 1'b0;
			clkchk_nxt = rsw_pkg::CLKCHK_RST;
			win_cnt_nxt = '0;
			armed_nxt = 1'b0;
		end
		else
		begin
			if (e_tick_r && win_open)
				win_cnt_nxt = win_cnt_r + 1'b1;
			// First write after reset wins in normal mode
			if (wr_cfg && (special || !dis_lock_r))
			begin
				wd_dis_nxt = HWDATA[rsw_pkg::CFG_WD_DIS_BIT];
				dis_lock_nxt = 1'b1;
			end
			if (wr_opt)
			begin
				clkchk_nxt = HWDATA[rsw_pkg::OPT_CLKCHK_BIT];
				if (special || (!rate_lock_r && win_open))
				begin
					rate_nxt = HWDATA[rsw_pkg::OPT_RATE_LSB +: 2];
					rate_lock_nxt = 1'b1;
				end
			end
			// Arming persists across any other traffic
			if (wr_svc && HWDATA[7:0] == rsw_pkg::SERVICE_ARM)
				armed_nxt = 1'b1;
			else if (svc_clear)
				armed_nxt = 1'b0;
		end
	end

	// Watchdog count on E ticks; a service clear beats expiry in the same cycle
	always_comb
	begin
		svc_clear = wr_svc && (HWDATA[7:0] == rsw_pkg::SERVICE_CLEAR) && armed_r;
		wd_fire = 1'b0;
		wd_cnt_nxt = wd_cnt_r;
		if (!run || wd_dis_r || svc_clear)
			wd_cnt_nxt = '0;
		else if (e_tick_r)
		begin
			if (wd_cnt_r == wd_limit(rate_r))
			begin
				wd_fire = 1'b1;
				wd_cnt_nxt = '0;
			end
			else
				wd_cnt_nxt = wd_cnt_r + 1'b1;
		end
	end

	// Reset sequencer: power delay, own pin drive, wait for the pin to rise
	always_comb
	begin
		state_nxt = state_r;
		rcnt_nxt = rcnt_r;
		ev = '0;
		case (state_r)
			rsw_pkg::RS_POWER:
			begin
				if (e_tick_r)
				begin
					rcnt_nxt = rcnt_r + 1'b1;
					if (rcnt_r == POR_LAST)
					begin
						rcnt_nxt = '0;
						state_nxt = rsw_pkg::RS_WAIT_HIGH;
					end
				end
			end
			rsw_pkg::RS_DRIVE:
			begin
				// Held for more than the eight-cycle distinction window
				if (e_tick_r)
				begin
					rcnt_nxt = rcnt_r + 1'b1;
					if (rcnt_r == DRIVE_LAST)
					begin
						rcnt_nxt = '0;
						state_nxt = rsw_pkg::RS_WAIT_HIGH;
					end
				end
			end
			rsw_pkg::RS_WAIT_HIGH:
			begin
				if (pin_s2_r)
					state_nxt = rsw_pkg::RS_RUN;
			end
			rsw_pkg::RS_RUN:
			begin
				if (wd_fire)
				begin
					ev[rsw_pkg::CAUSE_WD] = 1'b1;
					state_nxt = rsw_pkg::RS_DRIVE;
				end
				else if (clk_fail)
				begin
					ev[rsw_pkg::CAUSE_CLK] = 1'b1;
					state_nxt = rsw_pkg::RS_DRIVE;
				end
				else if (!pin_s2_r)
				begin
					ev[rsw_pkg::CAUSE_EXT] = 1'b1;
					state_nxt = rsw_pkg::RS_WAIT_HIGH;
				end
			end
			default: state_nxt = rsw_pkg::RS_POWER;
		endcase
		// Both follow the next state so the pin drive and reset rise together
		sys_rst_nxt = (state_nxt != rsw_pkg::RS_RUN);
		drive_nxt = (state_nxt == rsw_pkg::RS_DRIVE);
	end

	// Sticky causes, write one to clear; a new event wins over the clear
	always_comb
	begin
		status_nxt = (status_r & ~(wr_stat ? HWDATA[3:0] : 4'h0)) | ev;
		mask_nxt = wr_mask ? HWDATA[3:0] : mask_r;
		irq_nxt = |(status_nxt & mask_nxt);
	end

	// Registers of every group
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			spec_s1_r <= 1'b0;
			spec_s2_r <= 1'b0;
			e_cnt_r <= '0;
			e_tick_r <= 1'b0;
			wr_pend_r <= 1'b0;
			addr_r <= 8'h00;
			rdata_r <= 32'h0;
			wd_dis_r <= rsw_pkg::WD_DIS_RST;
			dis_lock_r <= 1'b0;
			rate_r <= rsw_pkg::RATE_RST;
			rate_lock_r <= 1'b0;
			clkchk_r <= rsw_pkg::CLKCHK_RST;
			win_cnt_r <= '0;
			armed_r <= 1'b0;
			wd_cnt_r <= '0;
			state_r <= rsw_pkg::RS_POWER;
			rcnt_r <= 16'h0;
			sys_rst_r <= 1'b1;
			drive_r <= 1'b0;
			status_r <= rsw_pkg::STATUS_RST;
			mask_r <= rsw_pkg::MASK_RST;
			irq_r <= 1'b0;
		end
		else
		begin
			pin_s1_r <= RESET_N_I;
			pin_s2_r <= pin_s1_r;
			spec_s1_r <= SPECIAL_MODE;
			spec_s2_r <= spec_s1_r;
			e_cnt_r <= e_cnt_nxt;
			e_tick_r <= e_tick_nxt;
			wr_pend_r <= wr_pend_nxt;
			addr_r <= addr_nxt;
			rdata_r <= rdata_nxt;
			wd_dis_r <= wd_dis_nxt;
			dis_lock_r <= dis_lock_nxt;
			rate_r <= rate_nxt;
			rate_lock_r <= rate_lock_nxt;
			clkchk_r <= clkchk_nxt;
			win_cnt_r <= win_cnt_nxt;
			armed_r <= armed_nxt;
			wd_cnt_r <= wd_cnt_nxt;
			state_r <= state_nxt;
			rcnt_r <= rcnt_nxt;
			sys_rst_r <= sys_rst_nxt;
			drive_r <= drive_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Outputs; the pin is only ever pulled low, never driven high
	assign HRDATA = rdata_r;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;
	assign RESET_N_O = 1'b0;
	assign RESET_N_OE = drive_r;
	assign SYS_RST = sys_rst_r;
	assign E_TICK = e_tick_r;
	assign IRQ = irq_r;
endmodule

// >>> shared/rsw_pkg.sv
// Constants shared by the reset-source and watchdog block.
// Assumes a 200 MHz system clock; the E clock is a divided enable.
package rsw_pkg;

	// System clock
	localparam int unsigned CLK_SYS_HZ = 200_000_000;
	localparam int unsigned CLK_SYS_NS = 5;

	// E clock as a divided enable (200 MHz / 100 = 2 MHz)
	localparam int unsigned E_DIV = 100;

	// Watchdog timebase is E / 2^15, then / 1, 4, 16 or 64
	localparam int unsigned WD_BASE_LOG2 = 15;
	localparam int unsigned WD_PRESCALE_BITS = 6;

	// Reset timing in E cycles
	localparam int unsigned OPT_WINDOW_E = 64;
	localparam int unsigned EXT_MIN_E = 8;
	localparam int unsigned DRIVE_E = 16;
	localparam int unsigned POR_DELAY_E = 4064;

	// Clock monitor: fail when no edge seen within a 10 kHz period
	localparam int unsigned CLKMON_FAIL_NS = 100_000;
	localparam int unsigned CLKMON_FAIL_CYC = CLKMON_FAIL_NS / CLK_SYS_NS;

	// Register byte offsets
	localparam logic [7:0] OFF_CONFIG = 8'h00;
	localparam logic [7:0] OFF_OPTION = 8'h04;
	localparam logic [7:0] OFF_SERVICE = 8'h08;
	localparam logic [7:0] OFF_STATUS = 8'h0C;
	localparam logic [7:0] OFF_MASK = 8'h10;
	localparam logic [7:0] OFF_STATE = 8'h14;
	localparam logic [7:0] OFF_WDCOUNT = 8'h18;

	// Field positions
	localparam int unsigned CFG_WD_DIS_BIT = 0;
	localparam int unsigned OPT_RATE_LSB = 0;
	localparam int unsigned OPT_CLKCHK_BIT = 3;
	localparam int unsigned CAUSE_EXT = 0;
	localparam int unsigned CAUSE_POR = 1;
	localparam int unsigned CAUSE_CLK = 2;
	localparam int unsigned CAUSE_WD = 3;
	localparam int unsigned NUM_CAUSES = 4;

	// Reset values
	localparam logic WD_DIS_RST = 1'b0;
	localparam logic [1:0] RATE_RST = 2'h0;
	localparam logic CLKCHK_RST = 1'b0;
	localparam logic [3:0] STATUS_RST = 4'h2;
	localparam logic [3:0] MASK_RST = 4'h0;

	// Service sequence values
	localparam logic [7:0] SERVICE_ARM = 8'h55;
	localparam logic [7:0] SERVICE_CLEAR = 8'hAA;

	// Reset sequencer states
	typedef enum logic [1:0] {
		RS_POWER = 2'b00,
		RS_DRIVE = 2'b01,
		RS_WAIT_HIGH = 2'b10,
		RS_RUN = 2'b11
	} rst_state_t;

endpackage

// >>> rtl/clock_check.sv
// Clock-loss detector for the monitored clock pin.
// Assumes the pin is asynchronous to CLK_SYS; it is synchronised here.
`timescale 1ns/1ps
module clock_check #(
	parameter int unsigned FAIL_CYC = rsw_pkg::CLKMON_FAIL_CYC
)(
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic enable,
	// Monitored pin
	input wire logic mon_pin,
	// Failure, one-cycle pulse
	output logic fail
);
	localparam int unsigned CW = $clog2(FAIL_CYC + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(FAIL_CYC - 1);

	logic s1_r, s2_r, s3_r;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic fail_r, fail_nxt;

	// Edge search; a running clock keeps restarting the count
	always_comb
	begin
		cnt_nxt = cnt_r + 1'b1;
		fail_nxt = 1'b0;
		if (!enable || (s2_r && !s3_r))
			cnt_nxt = '0;
		else if (cnt_r == CNT_LAST)
		begin
			cnt_nxt = '0;
			fail_nxt = 1'b1;
		end
	end

	// Two-stage synchroniser, then edge history and counter
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
			cnt_r <= '0;
			fail_r <= 1'b0;
		end
		else
		begin
			s1_r <= mon_pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			cnt_r <= cnt_nxt;
			fail_r <= fail_nxt;
		end
	end

	assign fail = fail_r;
endmodule

// >>> bench/rsw_checker.sv
// Port-level checks for the reset-source and watchdog block.
// Bound from the bench top; E_DIV must match the bound instance.
`timescale 1ns/1ps
module rsw_checker #(
	parameter int unsigned E_DIV = 4
)(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST,
	// Bus response
	input wire logic HREADYOUT,
	input wire logic HRESP,
	// Reset pin and system side
	input wire logic RESET_N_I,
	input wire logic RESET_N_O,
	input wire logic RESET_N_OE,
	input wire logic SYS_RST,
	input wire logic E_TICK
);
	int unsigned oe_r, oe_nxt, gap_r, gap_nxt;
	logic seen_r, seen_nxt;
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	// Drive length and tick spacing; first tick after reset has no reference
	always_comb
	begin
		oe_nxt = RESET_N_OE ? oe_r + 1 : 0;
		gap_nxt = E_TICK ? 0 : gap_r + 1;
		seen_nxt = seen_r | E_TICK;
	end
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			oe_r <= 0;
			gap_r <= 0;
			seen_r <= 1'b0;
		end
		else
		begin
			oe_r <= oe_nxt;
			gap_r <= gap_nxt;
			seen_r <= seen_nxt;
		end
	end
	chk_oe_in_reset: assert property (RESET_N_OE |-> SYS_RST)
		else $error("pin driven outside reset");
	chk_pin_causes_rst: assert property ($fell(RESET_N_I) |-> ##[1:3] SYS_RST)
		else $error("pin low did not reset");
	chk_low_pin_holds: assert property (!RESET_N_I [*4] |-> SYS_RST)
		else $error("running while pin low");
	chk_release_after_pin: assert property ($fell(SYS_RST) |-> $past(RESET_N_I) && $past(RESET_N_I, 3))
		else $error("reset left before pin high");
	chk_drive_length: assert property ($fell(RESET_N_OE) |-> oe_r >= 15 * E_DIV && oe_r <= 16 * E_DIV)
		else $error("pin drive length wrong");
	chk_drive_with_rst: assert property ($rose(RESET_N_OE) |-> $rose(SYS_RST))
		else $error("drive not tied to reset entry");
	chk_drive_level: assert property ($rose(RESET_N_OE) |-> (RESET_N_OE && !RESET_N_O) [*8])
		else $error("pin drive not held low");
	chk_tick_spacing: assert property (E_TICK && seen_r |-> gap_r == E_DIV - 1)
		else $error("E tick spacing wrong");
	chk_bus_okay: assert property (HREADYOUT && !HRESP)
		else $error("bus response not OKAY");
	cov_drive: cover property ($rose(RESET_N_OE));
	cov_run: cover property ($fell(SYS_RST));
	cov_ext: cover property ($fell(RESET_N_I) && !SYS_RST);
endmodule

// >>> bench/reset_pin_model.sv
// Outside party on the open-drain reset pin, with the pull-up.
// Any request is stretched to the minimum low time.
`timescale 1ns/1ps
module reset_pin_model #(
	parameter int unsigned MIN_CYC = 32
)(
	// Clock
	input wire logic clk,
	// Request and device driver
	input wire logic pull,
	input wire logic dev_o,
	input wire logic dev_oe,
	// Resolved pin level
	output logic pin
);
	int unsigned hold = 0;
	// Keep the pin low at least MIN_CYC after a request ends
	always @(posedge clk)
	begin
		if (pull)
			hold <= MIN_CYC;
		else if (hold != 0)
			hold <= hold - 1;
	end
	// Wired low if anyone pulls, else the pull-up wins
	assign pin = ((dev_oe && !dev_o) || pull || hold != 0) ? 1'b0 : 1'b1;
endmodule

// >>> bench/tb_reset_sources_watchdog.sv
// Self-checking bench for the reset-source and watchdog block.
// Counts are shortened by parameters; a pin model stands on the reset pin.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
`define WT(c) begin int k; k = 0; while (!(c) && k < 4000) begin @(posedge CLK_SYS); k++; end if (!(c)) begin n_mismatch++; print_verdict(); end end
module tb_reset_sources_watchdog;
	localparam int unsigned ED = 4;
	logic CLK_SYS, RST, HWRITE, pull, mon_run, ECLK_MON, hsel, smode;
	logic HREADYOUT, HRESP, RESET_N_I, RESET_N_O, RESET_N_OE, SYS_RST, E_TICK, IRQ;
	logic [1:0] HTRANS, mc;
	logic [31:0] HADDR, HWDATA, HRDATA, q, c1;
	int n_mismatch, comparisons, n;

	reset_sources_watchdog #(.E_DIV(ED), .WD_BASE_LOG2(3), .POR_DELAY_E(4),
		.CLKMON_FAIL_CYC(50)) reset_sources_watchdog_i (.CLK_SYS(CLK_SYS), .RST(RST),
		.HSEL(hsel), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
		.HREADY(HREADYOUT), .HWDATA(HWDATA), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
		.HRESP(HRESP), .RESET_N_I(RESET_N_I), .RESET_N_O(RESET_N_O),
		.RESET_N_OE(RESET_N_OE), .SPECIAL_MODE(smode), .ECLK_MON(ECLK_MON),
		.SYS_RST(SYS_RST), .E_TICK(E_TICK), .IRQ(IRQ));
	reset_pin_model #(.MIN_CYC(8 * ED)) reset_pin_model_i (.clk(CLK_SYS), .pull(pull),
		.dev_o(RESET_N_O), .dev_oe(RESET_N_OE), .pin(RESET_N_I));

	// Clock, and a monitored clock that stops when mon_run drops
	initial
	begin
		CLK_SYS = 1'b0;
		forever #2.5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS)
	begin
		mc <= mc + 2'h1;
		if (mc == 2'h3 && mon_run)
			ECLK_MON <= ~ECLK_MON;
	end

	task automatic print_verdict();
		$display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One single AHB transfer; read data lands in q
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		HTRANS <= 2'h2;
		HWRITE <= w;
		HADDR <= {24'h0, a};
		@(posedge CLK_SYS);
		`WT(HREADYOUT === 1'b1)
		HTRANS <= 2'h0;
		HWDATA <= d;
		@(posedge CLK_SYS);
		`WT(HREADYOUT === 1'b1)
		q = HRDATA;
	endtask

	// Pin still low after the power-on delay
	task automatic t_por_hold();
		repeat (ED * 4 + 20) @(posedge CLK_SYS);
		`CHK(SYS_RST, 1'b1)
		bus(1'b0, rsw_pkg::OFF_STATUS, 32'h0);
		`CHK(q, {28'h0, rsw_pkg::STATUS_RST})
		bus(1'b0, rsw_pkg::OFF_MASK, 32'h0);
		`CHK(q, 32'h0)
		pull <= 1'b0;
		`WT(SYS_RST === 1'b0)
	endtask

	// Rate lock, service pair, expiry time, interrupt mask and clear
	task automatic t_service();
		bus(1'b1, rsw_pkg::OFF_OPTION, 32'h3);
		bus(1'b1, rsw_pkg::OFF_OPTION, 32'h1);
		bus(1'b0, rsw_pkg::OFF_OPTION, 32'h0);
		`CHK(q, 32'h3)
		bus(1'b0, rsw_pkg::OFF_STATE, 32'h0);
		`CHK(q[4], 1'b1)
		repeat (20) @(posedge CLK_SYS);
		bus(1'b0, rsw_pkg::OFF_WDCOUNT, 32'h0);
		c1 = q;
		bus(1'b1, rsw_pkg::OFF_SERVICE, 32'hAA);
		bus(1'b0, rsw_pkg::OFF_WDCOUNT, 32'h0);
		`CHK(q > c1, 1'b1)
		bus(1'b1, rsw_pkg::OFF_SERVICE, {24'h0, rsw_pkg::SERVICE_ARM});
		bus(1'b0, rsw_pkg::OFF_OPTION, 32'h0);
		bus(1'b1, rsw_pkg::OFF_SERVICE, {24'h0, rsw_pkg::SERVICE_CLEAR});
		n = 0;
		while (SYS_RST !== 1'b1 && n < 3000)
		begin
			@(posedge CLK_SYS);
			n++;
		end
		// A watchdog that never fires ends the run here
		if (SYS_RST !== 1'b1)
		begin
			n_mismatch++;
			print_verdict();
		end
		// Period 2^(3+6) ticks of ED cycles; tick phase gives a few cycles of slack
		`CHK(n >= 512 * ED - 8 && n <= 512 * ED + 8, 1'b1)
		`CHK(RESET_N_OE, 1'b1)
		bus(1'b0, rsw_pkg::OFF_STATUS, 32'h0);
		`CHK(q, 32'hA)
		`CHK(IRQ, 1'b0)
		bus(1'b1, rsw_pkg::OFF_MASK, 32'h8);
		repeat (2) @(posedge CLK_SYS);
		`CHK(IRQ, 1'b1)
		bus(1'b1, rsw_pkg::OFF_STATUS, 32'h8);
		repeat (2) @(posedge CLK_SYS);
		`CHK(IRQ, 1'b0)
	endtask

	// Watchdog off, one-shot disable, clock monitor off then on
	task automatic t_disable();
		`WT(SYS_RST === 1'b0)
		bus(1'b1, rsw_pkg::OFF_CONFIG, 32'h1);
		bus(1'b1, rsw_pkg::OFF_CONFIG, 32'h0);
		bus(1'b0, rsw_pkg::OFF_CONFIG, 32'h0);
		`CHK(q, 32'h1)
		mon_run <= 1'b0;
		repeat (200) @(posedge CLK_SYS);
		`CHK(SYS_RST, 1'b0)
		mon_run <= 1'b1;
		repeat (20) @(posedge CLK_SYS);
		bus(1'b1, rsw_pkg::OFF_OPTION, 32'h8);
		repeat (100) @(posedge CLK_SYS);
		`CHK(SYS_RST, 1'b0)
		mon_run <= 1'b0;
		`WT(SYS_RST === 1'b1)
		`CHK(RESET_N_OE, 1'b1)
		bus(1'b0, rsw_pkg::OFF_STATUS, 32'h0);
		`CHK(q, 32'h6)
		mon_run <= 1'b1;
	endtask

	// Outside party pulls the pin; the block must not drive it
	task automatic t_ext();
		`WT(SYS_RST === 1'b0)
		bus(1'b1, rsw_pkg::OFF_CONFIG, 32'h1);
		bus(1'b1, rsw_pkg::OFF_STATUS, 32'hF);
		pull <= 1'b1;
		@(posedge CLK_SYS);
		pull <= 1'b0;
		`WT(SYS_RST === 1'b1)
		`CHK(RESET_N_OE, 1'b0)
		`CHK(RESET_N_I, 1'b0)
		bus(1'b0, rsw_pkg::OFF_STATUS, 32'h0);
		`CHK(q, 32'h1)
		`WT(SYS_RST === 1'b0)
	endtask

	// Special mode lets the rate be rewritten; a deselected write is ignored
	task automatic t_special();
		smode <= 1'b1;
		bus(1'b1, rsw_pkg::OFF_CONFIG, 32'h1);
		bus(1'b1, rsw_pkg::OFF_OPTION, 32'h1);
		bus(1'b1, rsw_pkg::OFF_OPTION, 32'h2);
		bus(1'b0, rsw_pkg::OFF_OPTION, 32'h0);
		`CHK(q, 32'h2)
		bus(1'b0, rsw_pkg::OFF_STATE, 32'h0);
		`CHK(q[3], 1'b1)
		hsel <= 1'b0;
		bus(1'b1, rsw_pkg::OFF_OPTION, 32'h3);
		hsel <= 1'b1;
		bus(1'b0, rsw_pkg::OFF_OPTION, 32'h0);
		`CHK(q, 32'h2)
		smode <= 1'b0;
	endtask

	// Main sequence; the pin is held low through power-up
	initial
	begin
		n_mismatch = 0;
		comparisons = 0;
		RST = 1'b1;
		HTRANS = 2'h0;
		HWRITE = 1'b0;
		HADDR = 32'h0;
		HWDATA = 32'h0;
		pull = 1'b1;
		hsel = 1'b1;
		smode = 1'b0;
		mon_run = 1'b1;
		ECLK_MON = 1'b0;
		mc = 2'h0;
		repeat (6) @(posedge CLK_SYS);
		RST <= 1'b0;
		@(posedge CLK_SYS);
		t_por_hold();
		t_service();
		t_disable();
		t_ext();
		t_special();
		print_verdict();
	end
endmodule

bind reset_sources_watchdog rsw_checker #(.E_DIV(E_DIV)) rsw_checker_i (.CLK_SYS(CLK_SYS),
	.RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RESET_N_I(RESET_N_I),
	.RESET_N_O(RESET_N_O), .RESET_N_OE(RESET_N_OE), .SYS_RST(SYS_RST), .E_TICK(E_TICK));
